// *** rtl/cms_pkg.sv ***
// shared constants, types and rate helpers for the mode transition smoother
package cms_pkg;
   typedef enum logic [1:0] {PREDICTION_MODE, TRANSFORM_EXCITATION_MODE, HIGH_QUALITY_TRANSFORM_MODE} cms_mode_t;
   typedef enum logic [1:0] {RATE_8K, RATE_16K, RATE_32K, RATE_48K} cms_rate_t;
   typedef enum logic [2:0] {VAR_NONE, VAR_1, VAR_2, VAR_3, VAR_PRED_TO_TRANSFORM} cms_variant_t;
   typedef enum logic [1:0] {ST_IDLE, ST_OVERLAP, ST_ZIR, ST_RUN} cms_state_t;

   localparam longint unsigned POSTFILTER_DELAY_NS = 64'd250000;
   localparam longint unsigned XFADE_END_8K_NS     = 64'd1250000;
   localparam longint unsigned XFADE_END_NS        = 64'd2312500;
   localparam longint unsigned FRAME_NS            = 64'd20000000;
   localparam longint unsigned OVERLAP_PPM         = 64'd1250;
   localparam int unsigned     PRED_RATE_LO_HZ     = 12800;
   localparam int unsigned     PRED_RATE_HI_HZ     = 16000;
   localparam int              LPC_ORDER           = 16;
   localparam int              ZIR_LEN             = 64;
   localparam int              ZIR_SHIFT           = 6;
   localparam int              HB_TAIL             = 16;
   localparam int              HB_TAIL_SHIFT       = 4;
   localparam int              WIN_FRAC            = 15;
   localparam int              COEF_FRAC           = 12;
   localparam int              INTERP_FRAC         = 8;
   localparam int              NT_MAX              = int'(OVERLAP_PPM * PRED_RATE_HI_HZ / 64'd1000000);
   localparam int              FIFO_DEPTH          = 16;

   function automatic int unsigned rate_hz(cms_rate_t r);
      int unsigned hz;
      hz = 8000;
      unique case (r)
         RATE_8K:  hz = 8000;
         RATE_16K: hz = 16000;
         RATE_32K: hz = 32000;
         RATE_48K: hz = 48000;
      endcase
      return hz;
   endfunction : rate_hz

   function automatic int unsigned ns_to_samples(longint unsigned ns, int unsigned hz);
      return int'(ns * 64'(hz) / 64'd1000000000);
   endfunction : ns_to_samples
endpackage : cms_pkg

// *** rtl/cms_fifo.sv ***
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cms_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;
   logic         full;
   logic         empty;

   assign empty     = (wr_ptr == rd_ptr);
   assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : cms_fifo

// *** rtl/cms_lerp.sv ***
// saturating linear blend a + (b - a) * w, weight in FRAC fraction bits
`timescale 1ns/1ps
module cms_lerp #(
   parameter int SW   = 16,
   parameter int FRAC = 15
) (
   // operands
   input  wire logic signed [SW-1:0] a,
   input  wire logic signed [SW-1:0] b,
   input  wire logic        [FRAC:0] w,
   // result
   output logic signed [SW-1:0]      y
);
   logic signed [SW:0]        diff;
   logic signed [SW+FRAC+2:0] prod;
   logic signed [SW+2:0]      sum;

   always_comb begin
      diff = $signed({b[SW-1], b}) - $signed({a[SW-1], a});
      prod = diff * $signed({1'b0, w});
      sum  = (SW+3)'(prod >>> FRAC) + (SW+3)'(a);
      if (sum > (SW+3)'(2 ** (SW - 1) - 1)) begin
         y = {1'b0, {(SW-1){1'b1}}};
      end else if (sum < -(SW+3)'(2 ** (SW - 1))) begin
         y = {1'b1, {(SW-1){1'b0}}};
      end else begin
         y = sum[SW-1:0];
      end
   end
endmodule : cms_lerp

// *** rtl/cms_smoother.sv ***
// mode transition smoother: cross-fade, zero-input response, output FIFO
// Notes on behaviour
// RL1 - pick one of three variants from mode, rate
// RL2 - variant two refreshes memories from prediction-rate stream
// RL3 - transform, then position-weighted fade, then prediction
// RL4 - fade starts after quarter-millisecond postfilter delay
// RL5 - fade ends 1.25ms at 8kHz, else 2.3125ms
// RL6 - output frames last twenty milliseconds
// RL7 - after high-quality transform: reset memories, same fade
// RL8 - transform after prediction: longer frame, modified slope
// RL9 - overlap is 0.00125 times prediction rate samples
// RL10 - order-16 coefficients from last prediction subframe
// RL11 - overlap-add plus reversed samples cancel aliasing
// RL12 - filter state is original minus modified signal
// RL13 - run zero-input recursion for 64 samples
// RL14 - weight response by remaining over total count
// RL15 - add windowed response to first prediction-rate samples
// RL16 - interpolate response to output rate, then add
// RL17 - fill high-band gap, fade its tail out
// RL18 - remember previous mode and past prediction samples
`timescale 1ns/1ps
module cms_smoother
   import cms_pkg::*;
#(
   parameter int SW = 16,
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic                                mclk,
   input  wire logic                                sys_rst,
   // frame control
   input  wire logic                                frame_start,
   input  wire cms_pkg::cms_mode_t                  cur_mode,
   input  wire logic                                low_rate,
   input  wire cms_pkg::cms_rate_t                  output_sample_rate,
   input  wire logic                                prediction_rate_16k,
   output logic                                     busy,
   output cms_pkg::cms_variant_t                    transition_variants,
   output logic                                     transform_extended_frame,
   output logic                                     mem_reset,
   // prediction filter coefficients and past samples
   input  wire logic                                lpc_load,
   input  wire logic [cms_pkg::LPC_ORDER-1:0][CW-1:0] lpc_coef,
   input  wire logic                                past_valid,
   input  wire logic signed [SW-1:0]                past_sample,
   // prediction-rate transform stream
   input  wire logic                                cr_valid,
   output logic                                     cr_ready,
   input  wire logic signed [SW-1:0]                cr_sample,
   input  wire logic [15:0]                         cr_win_a,
   input  wire logic [15:0]                         cr_win_b,
   output logic                                     cr_out_valid,
   input  wire logic                                cr_out_ready,
   output logic signed [SW-1:0]                     cr_out_sample,
   output logic                                     cr_mem_refresh,
   output logic                                     cr_resampler_refresh,
   // output-rate stream
   input  wire logic                                or_valid,
   output logic                                     or_ready,
   input  wire logic signed [SW-1:0]                or_transform,
   input  wire logic signed [SW-1:0]                or_pred,
   input  wire logic signed [SW-1:0]                or_hb_fill,
   output logic                                     out_valid,
   input  wire logic                                out_ready,
   output logic [SW-1:0]                            out_sample
);
   import cms_pkg::*;

   function automatic logic signed [SW-1:0] sat(input logic signed [SW+23:0] v);
      if (v > (SW+24)'(2 ** (SW - 1) - 1)) return {1'b0, {(SW-1){1'b1}}};
      if (v < -(SW+24)'(2 ** (SW - 1))) return {1'b1, {(SW-1){1'b0}}};
      return v[SW-1:0];
   endfunction : sat

   cms_state_t         state;
   cms_mode_t          prev_mode;
   logic [10:0]        or_n;
   logic [10:0]        or_len;
   logic [9:0]         cr_n;
   logic [9:0]         cr_len;
   logic [7:0]         dltp;
   logic [7:0]         delta;
   logic [15:0]        recip;
   logic [9:0]         step;
   logic [4:0]         nt;
   logic signed [SW-1:0] hist [NT_MAX];
   logic signed [CW-1:0] lpc [LPC_ORDER];
   logic signed [SW-1:0] zs [LPC_ORDER];
   logic signed [SW-1:0] zir_mem [ZIR_LEN];
   logic [5:0]         zi;
   logic [3:0]         mi;
   logic signed [39:0] acc;
   logic signed [39:0] total;
   logic signed [SW-1:0] s_new;
   logic signed [SW+23:0] win_z;
   logic               cr_take;
   logic               or_take;
   logic               fifo_ready;
   logic signed [SW-1:0] or_result;
   logic signed [47:0] wa2;
   logic signed [47:0] wab;
   logic signed [47:0] diff;
   logic [4:0]         zs_idx;
   logic [19:0]        pos;
   logic [11:0]        zidx;
   logic signed [SW-1:0] z0;
   logic signed [SW-1:0] z1;
   logic signed [SW-1:0] z_interp;
   logic [22:0]        fade_w;
   logic [15:0]        hb_w;
   logic signed [SW-1:0] fade_y;
   logic signed [SW-1:0] hb_keep;
   logic               is_t2p;
   cms_variant_t       next_variant;

   assign busy     = (state != ST_IDLE);
   assign is_t2p   = transition_variants inside {VAR_1, VAR_2, VAR_3};
   assign cr_take  = cr_valid && cr_ready;
   assign or_take  = or_valid && or_ready;
   assign cr_ready = (state == ST_OVERLAP) ||
                     ((state == ST_RUN) && (cr_n < cr_len) && (!cr_out_valid || cr_out_ready));
   assign or_ready = (state == ST_RUN) && (or_n < or_len) && fifo_ready;

   // low-rate switches from the excitation transform use the first variant
   always_comb begin
      next_variant = VAR_NONE;
      if (cur_mode == PREDICTION_MODE) begin
         if (prev_mode == HIGH_QUALITY_TRANSFORM_MODE) begin
            next_variant = VAR_3; // see RL1
         end else if (prev_mode == TRANSFORM_EXCITATION_MODE) begin
            next_variant = low_rate ? VAR_1 : VAR_2; // see RL1
         end
      end else if (cur_mode == TRANSFORM_EXCITATION_MODE && prev_mode == PREDICTION_MODE) begin
         next_variant = VAR_PRED_TO_TRANSFORM;
      end
   end

   // frame sequencing
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (frame_start) begin
                  state <= (next_variant == VAR_PRED_TO_TRANSFORM) ? ST_OVERLAP : ST_RUN;
               end
            end
            ST_OVERLAP: begin
               if (cr_take && cr_n == 10'(nt) - 10'd1) begin
                  state <= ST_ZIR;
               end
            end
            ST_ZIR: begin
               if (zi == 6'(ZIR_LEN - 1) && mi == 4'(LPC_ORDER - 1)) begin
                  state <= ST_RUN; // see RL13
               end
            end
            ST_RUN: begin
               if (or_n >= or_len && cr_n >= cr_len && !cr_out_valid) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // per-frame configuration
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_mode                <= PREDICTION_MODE;
         transition_variants      <= VAR_NONE;
         transform_extended_frame <= 1'b0;
         mem_reset                <= 1'b0;
         or_len <= '0;
         cr_len <= '0;
         dltp   <= '0;
         delta  <= '0;
         recip  <= '0;
         step   <= '0;
         nt     <= '0;
      end else begin
         mem_reset <= 1'b0;
         if (state == ST_IDLE && frame_start) begin
            prev_mode                <= cur_mode; // see RL18
            transition_variants      <= next_variant;
            // upstream lengthens the frame
            transform_extended_frame <= (next_variant == VAR_PRED_TO_TRANSFORM); // see RL8
            mem_reset                <= (next_variant == VAR_3); // see RL7
            or_len <= 11'(ns_to_samples(FRAME_NS, rate_hz(output_sample_rate))); // see RL6
            cr_len <= 10'(ns_to_samples(FRAME_NS, prediction_rate_16k ? PRED_RATE_HI_HZ : PRED_RATE_LO_HZ));
            dltp   <= 8'(ns_to_samples(POSTFILTER_DELAY_NS, rate_hz(output_sample_rate))); // see RL4
            delta  <= 8'(ns_to_samples((output_sample_rate == RATE_8K) ? XFADE_END_8K_NS : XFADE_END_NS,
                                       rate_hz(output_sample_rate))); // see RL5
            recip  <= 16'((32'd1 << WIN_FRAC) /
                          (ns_to_samples((output_sample_rate == RATE_8K) ? XFADE_END_8K_NS : XFADE_END_NS,
                                         rate_hz(output_sample_rate)) -
                           ns_to_samples(POSTFILTER_DELAY_NS, rate_hz(output_sample_rate))));
            step   <= 10'(((prediction_rate_16k ? PRED_RATE_HI_HZ : PRED_RATE_LO_HZ) << INTERP_FRAC) /
                          rate_hz(output_sample_rate));
            nt     <= 5'(OVERLAP_PPM * 64'(prediction_rate_16k ? PRED_RATE_HI_HZ : PRED_RATE_LO_HZ)
                         / 64'd1000000); // see RL9
         end
      end
   end

   // sample counters
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         or_n <= '0;
         cr_n <= '0;
      end else if (state == ST_IDLE) begin
         or_n <= '0;
         cr_n <= '0;
      end else begin
         if (or_take) begin
            or_n <= or_n + 11'd1;
         end
         if (state == ST_ZIR) begin
            cr_n <= '0;
         end else if (cr_take) begin
            cr_n <= cr_n + 10'd1;
         end
      end
   end

   // history shift, newest on top
   always_ff @(posedge mclk) begin
      if (past_valid) begin
         for (int i = 0; i < NT_MAX - 1; i++) begin
            hist[i] <= hist[i + 1];
         end
         hist[NT_MAX - 1] <= past_sample; // see RL18
      end
   end

   // coefficients of the last prediction subframe
   always_ff @(posedge mclk) begin
      if (lpc_load) begin
         for (int i = 0; i < LPC_ORDER; i++) begin
            lpc[i] <= $signed(lpc_coef[i]); // see RL10
         end
      end
   end

   // original minus modified past signal
   always_comb begin
      wa2    = (48'(cr_win_a) * 48'(cr_win_a)) >>> WIN_FRAC;
      wab    = (48'(cr_win_a) * 48'(cr_win_b)) >>> WIN_FRAC;
      diff   = ((48'(hist[5'(NT_MAX) - nt + 5'(cr_n)]) * ((48'sd1 <<< WIN_FRAC) - wa2)) >>> WIN_FRAC)
               - 48'(cr_sample)
               - ((48'(hist[5'(NT_MAX - 1) - 5'(cr_n)]) * wab) >>> WIN_FRAC); // see RL11
      zs_idx = 5'(cr_n) - (nt - 5'(LPC_ORDER));
   end

   // zero-input recursion, one tap per cycle
   always_comb begin
      total = acc + 40'($signed(lpc[mi]) * zs[4'(LPC_ORDER - 1) - mi]);
      s_new = sat(-(40'(total >>> COEF_FRAC)));
      win_z = ((SW+24)'(s_new) * (SW+24)'($signed({1'b0, 7'(ZIR_LEN) - {1'b0, zi}}))) >>> ZIR_SHIFT; // see RL14
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         zi  <= '0;
         mi  <= '0;
         acc <= '0;
      end else if (state == ST_ZIR) begin
         if (mi == 4'(LPC_ORDER - 1)) begin
            mi  <= '0;
            acc <= '0;
            zi  <= zi + 6'd1;
         end else begin
            mi  <= mi + 4'd1;
            acc <= total; // see RL13
         end
      end else begin
         zi  <= '0;
         mi  <= '0;
         acc <= '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (state == ST_OVERLAP && cr_take && 5'(cr_n) >= nt - 5'(LPC_ORDER)) begin
         zs[zs_idx[3:0]] <= sat((SW+24)'(diff)); // see RL12
      end else if (state == ST_ZIR && mi == 4'(LPC_ORDER - 1)) begin
         for (int i = 0; i < LPC_ORDER - 1; i++) begin
            zs[i] <= zs[i + 1];
         end
         zs[LPC_ORDER - 1] <= s_new;
         zir_mem[zi]       <= sat(win_z);
      end
   end

   // prediction-rate output and refresh flags
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cr_out_valid         <= 1'b0;
         cr_out_sample        <= '0;
         cr_mem_refresh       <= 1'b0;
         cr_resampler_refresh <= 1'b0;
      end else if (state == ST_RUN && cr_take) begin
         cr_out_valid         <= 1'b1;
         cr_mem_refresh       <= (transition_variants == VAR_1) || (transition_variants == VAR_2); // see RL2
         cr_resampler_refresh <= (transition_variants == VAR_2); // see RL2
         if (transition_variants == VAR_PRED_TO_TRANSFORM && cr_n < 10'(ZIR_LEN)) begin
            cr_out_sample <= sat((SW+24)'(cr_sample) + (SW+24)'(zir_mem[cr_n[5:0]])); // see RL15
         end else begin
            cr_out_sample <= cr_sample;
         end
      end else if (cr_out_ready) begin
         cr_out_valid <= 1'b0;
      end
   end

   // response beyond its end reads as zero
   always_comb begin
      pos    = 20'(or_n) * 20'(step);
      zidx   = pos[19:INTERP_FRAC];
      z0     = (zidx < 12'(ZIR_LEN)) ? zir_mem[zidx[5:0]] : '0;
      z1     = (zidx < 12'(ZIR_LEN - 1)) ? zir_mem[6'(zidx + 12'd1)] : '0;
      fade_w = 23'(or_n - 11'(dltp)) * 23'(recip);
      hb_w   = 16'(or_n - 11'(delta)) << (WIN_FRAC - HB_TAIL_SHIFT);
   end

   cms_lerp #(.SW(SW), .FRAC(WIN_FRAC)) u_fade (
      .a (or_transform),
      .b (or_pred),
      .w (fade_w[WIN_FRAC:0]),
      .y (fade_y)
   );

   cms_lerp #(.SW(SW), .FRAC(INTERP_FRAC)) u_interp (
      .a (z0),
      .b (z1),
      .w ({1'b0, pos[INTERP_FRAC-1:0]}),
      .y (z_interp)
   );

   cms_lerp #(.SW(SW), .FRAC(WIN_FRAC)) u_hb_tail (
      .a (or_hb_fill),
      .b ('0),
      .w (hb_w),
      .y (hb_keep)
   );

   always_comb begin
      or_result = or_transform;
      if (is_t2p) begin
         if (or_n < 11'(dltp)) begin
            or_result = or_transform; // see RL3
         end else if (or_n < 11'(delta)) begin
            or_result = fade_y; // see RL3
         end else begin
            or_result = or_pred; // see RL3
         end
      end else if (transition_variants == VAR_PRED_TO_TRANSFORM) begin
         // gap spans the extension delay; short fixed tail
         if (or_n < 11'(delta)) begin
            or_result = sat((SW+24)'(or_transform) + (SW+24)'(z_interp) + (SW+24)'(or_hb_fill)); // see RL17
         end else if (or_n < 11'(delta) + 11'(HB_TAIL)) begin
            or_result = sat((SW+24)'(or_transform) + (SW+24)'(z_interp) + (SW+24)'(hb_keep)); // see RL17
         end else begin
            or_result = sat((SW+24)'(or_transform) + (SW+24)'(z_interp)); // see RL16
         end
      end else if (prev_mode == PREDICTION_MODE) begin
         or_result = or_pred;
      end
   end

   // a stalled consumer holds the output-rate stream back
   cms_fifo #(.W(SW), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (or_take),
      .in_ready  (fifo_ready),
      .in_data   (or_result),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_sample)
   );
endmodule : cms_smoother

// *** test/cms_smoother_sva.sv ***
// assertions on the ports of the mode transition smoother
`timescale 1ns/1ps
module cms_smoother_sva
   import cms_pkg::*;
#(parameter int SW = 16, parameter int CW = 16) (
   // clock, reset and frame control
   input wire logic               mclk,
   input wire logic               sys_rst,
   input wire logic               frame_start,
   input wire logic               busy,
   input wire cms_pkg::cms_variant_t transition_variants,
   input wire logic               transform_extended_frame,
   input wire logic               mem_reset,
   // streams
   input wire logic               cr_ready,
   input wire logic               cr_out_valid,
   input wire logic               cr_out_ready,
   input wire logic signed [SW-1:0] cr_out_sample,
   input wire logic               cr_mem_refresh,
   input wire logic               cr_resampler_refresh,
   input wire logic               or_valid,
   input wire logic               or_ready,
   input wire logic               out_valid,
   input wire logic               out_ready,
   input wire logic [SW-1:0]      out_sample
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_busy_start: assert property (frame_start && !busy |=> busy) else $error("busy late");
   a_ext_var: assert property (busy |-> transform_extended_frame == (transition_variants == VAR_PRED_TO_TRANSFORM))
      else $error("extended flag wrong");
   a_mem_reset_var: assert property (frame_start && !busy |=> mem_reset == (transition_variants == VAR_3))
      else $error("memory reset wrong");
   a_mem_reset_one: assert property (mem_reset |=> !mem_reset) else $error("memory reset too long");
   a_refresh_both: assert property (cr_out_valid && transition_variants == VAR_2 |-> cr_mem_refresh && cr_resampler_refresh)
      else $error("refresh flags wrong");
   a_refresh_one: assert property (cr_out_valid && transition_variants == VAR_1 |-> cr_mem_refresh && !cr_resampler_refresh)
      else $error("refresh flag wrong");
   a_cr_out_hold: assert property (cr_out_valid && !cr_out_ready |=> cr_out_valid && $stable(cr_out_sample))
      else $error("cr output dropped");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample)) else $error("output dropped");
   a_idle_refuse: assert property (!busy |-> !cr_ready && !or_ready) else $error("ready while idle");
   a_fifo_answer: assert property (or_valid && or_ready && !out_valid |=> out_valid) else $error("fifo late");
endmodule : cms_smoother_sva
bind cms_smoother cms_smoother_sva #(.SW(SW), .CW(CW)) i_sva (.*);

// *** test/cms_pred_src.sv ***
// prediction-rate source and drain standing in for the upstream decoder stages
`timescale 1ns/1ps
module cms_pred_src (
   // clock, reset and frame setup
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   input  wire logic          go,
   input  wire logic [8:0]    total,
   // prediction-rate stream
   output logic               cr_valid,
   input  wire logic          cr_ready,
   output logic signed [15:0] cr_sample,
   output logic [15:0]        cr_win_a,
   output logic [15:0]        cr_win_b,
   input  wire logic          cr_out_valid,
   output logic               cr_out_ready
);
   int   cnt = 0;
   int   seed = 80049;
   logic took = 1'b0;
   logic nv;
   initial {cr_valid, cr_out_ready, cr_sample, cr_win_a, cr_win_b} = '0;
   always @(posedge mclk) took <= cr_valid & cr_ready;
   // silent samples keep the response state zero
   always @(negedge mclk) begin
      cnt = go ? 0 : cnt + int'(took);
      nv = !sys_rst && !go && cnt < int'(total);
      cr_valid <= nv;
      cr_sample <= nv ? 16'sh0000 : 16'($random(seed));
      cr_win_a <= nv ? 16'h0000 : 16'($random(seed));
      cr_win_b <= nv ? 16'h0000 : 16'($random(seed));
      cr_out_ready <= ($random(seed) & 3) != 0;
   end
endmodule : cms_pred_src

// *** test/testbench.sv ***
// self-checking bench for the mode transition smoother
`timescale 1ns/1ps
module testbench;
   import cms_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, frame_start = 1'b0, low_rate = 1'b0, prediction_rate_16k = 1'b0;
   logic lpc_load = 1'b0, past_valid = 1'b0, or_valid = 1'b0, out_ready = 1'b0, go = 1'b0, stall = 1'b0;
   logic busy, cr_ready, cr_valid, cr_out_valid, cr_out_ready, cr_mem_refresh, cr_resampler_refresh;
   logic transform_extended_frame, mem_reset, or_ready, out_valid;
   cms_mode_t cur_mode = PREDICTION_MODE, prev = PREDICTION_MODE;
   cms_rate_t output_sample_rate = RATE_8K;
   cms_variant_t transition_variants;
   logic [LPC_ORDER-1:0][15:0] lpc_coef = '0;
   logic signed [15:0] past_sample = '0, or_transform = '0, or_pred = '0, or_hb_fill = '0, cr_sample, cr_out_sample;
   logic [15:0] cr_win_a, cr_win_b, out_sample;
   logic [8:0] total = 9'h000;
   logic [15:0] exp_q[$];
   int fail_count = 0, check_count = 0, seed = 80049;
   always #10 mclk = ~mclk;
   cms_smoother i_dut (.*);
   cms_pred_src i_src (.*);
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // fade edges per rate: 2/4/8/12 and 10/37/74/111 samples
   function automatic int expect_out(int t, int p, int h, int n, int r, cms_mode_t pm, cms_mode_t cm);
      int dl;
      int dt;
      dl = (r == 0) ? 2 : 4 * r;
      dt = (r == 0) ? 10 : 37 * r;
      if (pm == PREDICTION_MODE && cm == TRANSFORM_EXCITATION_MODE) begin
         if (n < dt) return t + h;
         if (n < dt + 16) return t + ((h * (16 - n + dt)) >>> 4);
         return t;
      end
      if (cm != PREDICTION_MODE) return t;
      if (pm == PREDICTION_MODE) return p;
      if (n < dl) return t;
      if (n < dt) return t + (((p - t) * (n - dl) * (32768 / (dt - dl))) >>> 15);
      return p;
   endfunction : expect_out
   task automatic wait_idle;
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge mclk);
      if (busy !== 1'b0) begin
         check("busy_timeout", 16'h0001, 16'h0000);
         stop_test();
      end
   endtask : wait_idle
   task automatic frame(input cms_mode_t cm, input logic lr, input int r);
      cms_variant_t ev;
      int t, p, h, ok;
      ev = VAR_NONE;
      if (prev == PREDICTION_MODE && cm == TRANSFORM_EXCITATION_MODE) ev = VAR_PRED_TO_TRANSFORM;
      if (prev != PREDICTION_MODE && cm == PREDICTION_MODE) ev = (prev == HIGH_QUALITY_TRANSFORM_MODE) ? VAR_3 : (lr ? VAR_1 : VAR_2);
      wait_idle();
      @(negedge mclk);
      frame_start <= 1'b1;
      cur_mode <= cm;
      low_rate <= lr;
      output_sample_rate <= cms_rate_t'(r);
      go <= 1'b1;
      total <= (ev == VAR_PRED_TO_TRANSFORM) ? 9'd272 : 9'd256;
      @(negedge mclk);
      frame_start <= 1'b0;
      go <= 1'b0;
      check("busy", 16'(busy), 16'h0001);
      check("variant", 16'(transition_variants), 16'(ev));
      check("extended", 16'(transform_extended_frame), 16'(ev == VAR_PRED_TO_TRANSFORM));
      check("mem_reset", 16'(mem_reset), 16'(ev == VAR_3));
      for (int n = 0; n < ((r == 0) ? 160 : 320 * r); n++) begin
         t = $random(seed) % 4096;
         p = $random(seed) % 4096;
         h = $random(seed) % 4096;
         exp_q.push_back(16'(expect_out(t, p, h, n, r, prev, cm)));
         ok = 0;
         // stall fills the fifo
         if (n == 20) stall <= 1'b1;
         for (int i = 0; i < 3000 && !ok; i++) begin
            @(negedge mclk);
            if (i == 60) stall <= 1'b0;
            or_valid <= 1'b1;
            or_transform <= 16'(t);
            or_pred <= 16'(p);
            or_hb_fill <= 16'(h);
            #1 ok = (or_ready === 1'b1);
         end
         if (!ok) check("or_timeout", 16'h0001, 16'h0000);
      end
      @(negedge mclk);
      or_valid <= 1'b0;
      or_transform <= 16'($random(seed));
      prev = cm;
   endtask : frame
   always @(negedge mclk) out_ready <= !stall && (($random(seed) & 3) != 0);
   always @(posedge mclk) begin
      if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() > 0) check("out_sample", out_sample, exp_q.pop_front());
         else check("out_extra", 16'h0001, 16'h0000);
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      sys_rst <= 1'b0;
      lpc_load <= 1'b1;
      lpc_coef <= {8{32'($random(seed))}};
      past_valid <= 1'b1;
      @(negedge mclk);
      lpc_load <= 1'b0;
      repeat (19) @(negedge mclk);
      past_valid <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         frame(TRANSFORM_EXCITATION_MODE, 1'b0, r);
         frame(PREDICTION_MODE, r == 1, r);
      end
      frame(HIGH_QUALITY_TRANSFORM_MODE, 1'b0, 0);
      frame(PREDICTION_MODE, 1'b0, 2);
      frame(PREDICTION_MODE, 1'b0, 3);
      wait_idle();
      for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(negedge mclk);
      check("drained", 16'(exp_q.size()), 16'h0000);
      stop_test();
   end
endmodule : testbench
